// file: hw/usr_defines.svh
// usr_defines.svh: offsets, field positions and reset values of the
// endpoint-0 standard request handler
// assumes word addressing on the register bus
`ifndef USR_DEFINES_SVH
`define USR_DEFINES_SVH

// register word addresses
`define USR_REG_CTRL     4'h0
`define USR_REG_IRQ_STAT 4'h1
`define USR_REG_IRQ_MASK 4'h2
`define USR_REG_ACTIVE   4'h3
`define USR_REG_SETUP_LO 4'h4
`define USR_REG_SETUP_HI 4'h5
`define USR_REG_ADDR     4'h6
`define USR_REG_HALT     4'h7
`define USR_REG_SYNC     4'h8

// control register fields
`define USR_CTRL_ACK 0
`define USR_CTRL_PWR 1
`define USR_CTRL_CT  3:2

// interrupt status and mask bits
`define USR_NIRQ     4
`define USR_IRQ_CHG  0
`define USR_IRQ_SET  1
`define USR_IRQ_STS  2
`define USR_IRQ_GIF  3

// setup packet fields
`define USR_F_TYPE 6:5
`define USR_F_RCP  4:0
`define USR_F_REQ  15:8
`define USR_F_VAL  31:16
`define USR_F_IDX  47:32

`define USR_RCP_DEV   5'h00
`define USR_RCP_IF    5'h01
`define USR_RCP_EP    5'h02
`define USR_FEAT_HALT 16'h0000
`define USR_FEAT_WAKE 16'h0001
`define USR_LEN_BYTE  2'h1
`define USR_LEN_WORD  2'h2

// reset values
`define USR_ACTIVE_RST 12'h000
`define USR_PWR_RST    1'h0
`define USR_ADDR_RST   7'h00

`endif

// file: hw/usr_pkg.sv
// usr_pkg: types shared by the endpoint-0 request handler
// assumes nothing of its surroundings
package usr_pkg;

  typedef enum logic [7:0] {
    GET_STATUS  = 8'h00,
    CLR_FEATURE = 8'h01,
    SET_FEATURE = 8'h03,
    SET_ADDRESS = 8'h05,
    GET_DESC    = 8'h06,
    SET_DESC    = 8'h07,
    GET_CONFIG  = 8'h08,
    SET_CONFIG  = 8'h09,
    GET_IFACE   = 8'h0A,
    SET_IFACE   = 8'h0B,
    SYNCH_FRAME = 8'h0C
  } usr_req_t;

  typedef enum logic [1:0] {
    CT_IDLE = 2'b00,
    CT_AUTO = 2'b01,
    CT_CPU  = 2'b10
  } usr_ct_t;

endpackage

// file: hw/usr_req_if.sv
// usr_req_if: a setup packet and its decoded fields
// assumes the packet is held stable while it is decoded
`timescale 1ns/1ps
interface usr_req_if
  import usr_pkg::*;
();
  logic [63:0] pkt;
  logic        std;
  usr_req_t    code;
  logic [4:0]  recip;
  logic [15:0] wvalue;
  logic [15:0] windex;
  logic        forward;

  modport dec (input pkt, output std, code, recip, wvalue, windex, forward);
  modport src (output pkt, input std, code, recip, wvalue, windex, forward);
endinterface

// file: hw/usr_setup_dec.sv
// usr_setup_dec: splits a setup packet and decides who serves it
// assumes the packet bytes are little endian, byte 0 in bits 7:0
`timescale 1ns/1ps
`include "usr_defines.svh"
module usr_setup_dec
  import usr_pkg::*;
(
  usr_req_if.dec rq
);
  always_comb begin
    rq.std    = rq.pkt[`USR_F_TYPE] == 2'h0;
    rq.code   = usr_req_t'(rq.pkt[`USR_F_REQ]);
    rq.recip  = rq.pkt[`USR_F_RCP];
    rq.wvalue = rq.pkt[`USR_F_VAL];
    rq.windex = rq.pkt[`USR_F_IDX];
    // descriptor, synch, class, vendor and unknown codes go to firmware
    rq.forward = !(rq.std && (rq.code inside {GET_STATUS, CLR_FEATURE,
      SET_FEATURE, SET_ADDRESS, GET_CONFIG, SET_CONFIG,
      GET_IFACE, SET_IFACE}));
  end
endmodule // usr_setup_dec

// file: hw/usr_irq.sv
// usr_irq: sticky event flags, mask and one level interrupt
// assumes write strobes last one cycle and come from the clk domain
`timescale 1ns/1ps
module usr_irq
  import usr_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] evt,
  input  wire logic         stat_we,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] stat,
  output logic      [N-1:0] mask,
  output logic              irq
);
  logic [N-1:0] stat_r;
  logic [N-1:0] mask_r;
  logic [N-1:0] clr;

  assign clr = stat_we ? wdata : '0;

  // an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (reset) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~clr) | evt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r <= '0;
    end else if (mask_we) begin
      mask_r <= wdata;
    end
  end

  assign stat = stat_r;
  assign mask = mask_r;
  assign irq  = |(stat_r & mask_r);

  property p_set_wins;
    @(posedge clk) disable iff (reset)
      (|evt) |=> ((stat_r & $past(evt)) == $past(evt));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event flag lost");
endmodule // usr_irq

// file: hw/usr_std_req.sv
// usr_std_req: endpoint-0 standard request handler with avalon registers
// assumes setup, status and sof strobes come from link logic on clk
//
// Contract
// - only descriptor, synch, class, vendor and unknown requests reach cpu
// - configuration and interface selects done in hardware
// - cpu reads active config, interface, alternate
// - clear feature: endpoint halt or remote wakeup
// - set feature: endpoint halt or remote wakeup
// - new address only after status stage completes
// - operation done before status stage acknowledged
// - every get descriptor goes to the cpu
// - get configuration returns value, zero unconfigured
// - get interface answered here, cpu only notified
// - get interface valid only when configured
// - set interface activates chosen alternate setting
// - get status returns recipient status word
// - synch frame uses last sof before pattern
// - no stall for missing interfaces or endpoints
// - active setting change sets maskable flag
// - forwarded setup raises setup interrupt
`timescale 1ns/1ps
`include "usr_defines.svh"
module usr_std_req
  import usr_pkg::*;
#(
  parameter int N_EP = 16,
  parameter int N_IF = 15
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        setup_valid,
  input  wire logic [63:0] setup_pkt,
  input  wire logic        status_req,
  input  wire logic        status_done,
  input  wire logic        sof_valid,
  input  wire logic [10:0] sof_frame,
  input  wire logic        pattern_start,
  output logic      [6:0]  dev_addr,
  output logic             status_ack_en,
  output logic             resp_valid,
  output logic      [15:0] resp_data,
  output logic      [1:0]  resp_len,
  output logic             resp_stall,
  output logic [N_EP-1:0]  ep_halt,
  output logic             remote_wake_en,
  output logic             irq
);

  usr_req_if rq ();

  usr_setup_dec u_dec (
    .rq (rq.dec)
  );

  assign rq.pkt = setup_pkt;

  // decoded request strobes
  function automatic logic is_req(input usr_req_t c);
    return setup_valid && rq.std && rq.code == c;
  endfunction

  logic req_get_sts;
  logic req_clr_feat;
  logic req_set_feat;
  logic req_set_addr;
  logic req_get_cfg;
  logic req_set_cfg;
  logic req_get_if;
  logic req_set_if;

  assign req_get_sts  = is_req(GET_STATUS);
  assign req_clr_feat = is_req(CLR_FEATURE);
  assign req_set_feat = is_req(SET_FEATURE);
  assign req_set_addr = is_req(SET_ADDRESS);
  assign req_get_cfg  = is_req(GET_CONFIG);
  assign req_set_cfg  = is_req(SET_CONFIG);
  assign req_get_if   = is_req(GET_IFACE);
  assign req_set_if   = is_req(SET_IFACE);

  logic [3:0] ep_n;
  logic [3:0] if_n;
  logic       ep_ok;
  logic       if_ok;
  logic       configured;

  assign ep_n  = rq.windex[3:0];
  assign if_n  = rq.windex[3:0];
  // unknown targets are ignored quietly rather than stalled
  assign ep_ok = rq.recip == `USR_RCP_EP && ({1'b0, ep_n} < 5'(N_EP));
  // whole index compared so a high interface number cannot alias a low one
  assign if_ok = rq.windex < 16'(N_IF);

  // register bus: every access answers one cycle after it is raised
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic        wr_go;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go           = avs_write & ack_r;
  assign avs_readdata    = rdata_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (avs_read && !ack_r) begin
      rdata_r <= rd_mux;
    end
  end

  // control transfer state
  usr_ct_t ct_r;
  logic    ack_en_r;
  logic    pwr_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      ct_r <= CT_IDLE;
    end else if (setup_valid) begin
      ct_r <= rq.forward ? CT_CPU : CT_AUTO;
    end else if (status_done) begin
      ct_r <= CT_IDLE;
    end
  end

  // a new setup withdraws any earlier firmware permission
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_en_r <= 1'b0;
    end else if (setup_valid || status_done) begin
      ack_en_r <= 1'b0;
    end else if (wr_go && avs_address == `USR_REG_CTRL) begin
      ack_en_r <= ack_en_r | avs_writedata[`USR_CTRL_ACK];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_r <= `USR_PWR_RST;
    end else if (wr_go && avs_address == `USR_REG_CTRL) begin
      pwr_r <= avs_writedata[`USR_CTRL_PWR];
    end
  end

  // hardware work lands on the setup edge, so ack follows it
  assign status_ack_en = ~setup_valid & ((ct_r == CT_AUTO)
    | (ct_r == CT_CPU & ack_en_r));

  // setup packet kept for firmware
  logic [63:0] setup_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      setup_r <= '0;
    end else if (setup_valid) begin
      setup_r <= setup_pkt;
    end
  end

  // configuration, per-interface alternates and the active report
  logic [3:0]  cfg_r;
  logic [3:0]  alt_r [N_IF];
  logic [11:0] active_r;
  logic [11:0] active_nxt;

  assign configured = cfg_r != 4'h0;

  always_comb begin
    active_nxt = active_r;
    if (req_set_cfg) begin
      active_nxt = {rq.wvalue[3:0], 4'h0, 4'h0};
    end else if (req_set_if && configured && if_ok) begin
      active_nxt = {cfg_r, if_n, rq.wvalue[3:0]};
    end
  end

  // whole report moves on one edge, never half old half new
  always_ff @(posedge clk) begin
    if (reset) begin
      active_r <= `USR_ACTIVE_RST;
    end else begin
      active_r <= active_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r <= '0;
      for (int i = 0; i < N_IF; i++) begin
        alt_r[i] <= '0;
      end
    end else if (req_set_cfg) begin
      cfg_r <= rq.wvalue[3:0];
      for (int i = 0; i < N_IF; i++) begin
        alt_r[i] <= '0;
      end
    end else if (req_set_if && configured && if_ok) begin
      alt_r[if_n] <= rq.wvalue[3:0];
    end
  end

  // device address takes effect after the status stage
  logic [6:0] pend_addr_r;
  logic       addr_pend_r;
  logic [6:0] dev_addr_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_addr_r <= `USR_ADDR_RST;
      addr_pend_r <= 1'b0;
      dev_addr_r  <= `USR_ADDR_RST;
    end else if (setup_valid) begin
      pend_addr_r <= rq.wvalue[6:0];
      addr_pend_r <= req_set_addr;
    end else if (status_done && addr_pend_r) begin
      dev_addr_r  <= pend_addr_r;
      addr_pend_r <= 1'b0;
    end
  end

  assign dev_addr = dev_addr_r;

  // features
  logic [N_EP-1:0] halt_r;
  logic            wake_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      halt_r <= '0;
      wake_r <= 1'b0;
    end else if (req_clr_feat || req_set_feat) begin
      if (ep_ok && rq.wvalue == `USR_FEAT_HALT) begin
        halt_r[ep_n] <= req_set_feat;
      end
      if (rq.recip == `USR_RCP_DEV && rq.wvalue == `USR_FEAT_WAKE) begin
        wake_r <= req_set_feat;
      end
    end
  end

  assign ep_halt        = halt_r;
  assign remote_wake_en = wake_r;

  // data stage answers for requests served here
  logic        resp_valid_r;
  logic        resp_stall_r;
  logic [15:0] resp_data_r;
  logic [1:0]  resp_len_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      resp_valid_r <= 1'b0;
      resp_stall_r <= 1'b0;
      resp_data_r  <= '0;
      resp_len_r   <= '0;
    end else if (setup_valid) begin
      resp_valid_r <= 1'b0;
      resp_stall_r <= 1'b0;
      resp_data_r  <= '0;
      resp_len_r   <= `USR_LEN_BYTE;
      if (req_get_sts) begin
        resp_valid_r <= 1'b1;
        resp_len_r   <= `USR_LEN_WORD;
        if (rq.recip == `USR_RCP_DEV) begin
          resp_data_r <= {14'h0000, wake_r, pwr_r};
        end else if (ep_ok) begin
          resp_data_r <= {15'h0000, halt_r[ep_n]};
        end
      end else if (req_get_cfg) begin
        resp_valid_r <= 1'b1;
        resp_data_r  <= {12'h000, cfg_r};
      end else if (req_get_if) begin
        resp_valid_r <= configured;
        resp_stall_r <= !configured;
        if (configured && if_ok) begin
          resp_data_r <= {12'h000, alt_r[if_n]};
        end
      end else if (req_set_if) begin
        resp_stall_r <= !configured;
      end
    end else if (status_done) begin
      resp_valid_r <= 1'b0;
      resp_stall_r <= 1'b0;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_stall = resp_stall_r;
  assign resp_data  = resp_data_r;
  assign resp_len   = resp_len_r;

  // frame reference for the firmware's synch answer
  logic [10:0] last_sof_r;
  logic [10:0] sync_frame_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      last_sof_r   <= '0;
      sync_frame_r <= '0;
    end else begin
      if (sof_valid) begin
        last_sof_r <= sof_frame;
      end
      if (pattern_start) begin
        sync_frame_r <= last_sof_r;
      end
    end
  end

  // interrupts
  logic [`USR_NIRQ-1:0] evt;
  logic [`USR_NIRQ-1:0] irq_stat;
  logic [`USR_NIRQ-1:0] irq_mask;

  always_comb begin
    evt               = '0;
    evt[`USR_IRQ_CHG] = active_nxt != active_r;
    evt[`USR_IRQ_SET] = setup_valid && rq.forward;
    evt[`USR_IRQ_STS] = status_req && !status_ack_en;
    evt[`USR_IRQ_GIF] = req_get_if;
  end

  usr_irq #(
    .N (`USR_NIRQ)
  ) u_irq (
    .clk     (clk),
    .reset   (reset),
    .evt     (evt),
    .stat_we (wr_go && avs_address == `USR_REG_IRQ_STAT),
    .mask_we (wr_go && avs_address == `USR_REG_IRQ_MASK),
    .wdata   (avs_writedata[`USR_NIRQ-1:0]),
    .stat    (irq_stat),
    .mask    (irq_mask),
    .irq     (irq)
  );

  // register read map
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      `USR_REG_CTRL: begin
        rd_mux[`USR_CTRL_ACK] = ack_en_r;
        rd_mux[`USR_CTRL_PWR] = pwr_r;
        rd_mux[`USR_CTRL_CT]  = ct_r;
      end
      `USR_REG_IRQ_STAT: rd_mux = 32'(irq_stat);
      `USR_REG_IRQ_MASK: rd_mux = 32'(irq_mask);
      `USR_REG_ACTIVE:   rd_mux = 32'(active_r);
      `USR_REG_SETUP_LO: rd_mux = setup_r[31:0];
      `USR_REG_SETUP_HI: rd_mux = setup_r[63:32];
      `USR_REG_ADDR:     rd_mux = 32'(dev_addr_r);
      `USR_REG_HALT:     rd_mux = 32'(halt_r);
      `USR_REG_SYNC:     rd_mux = 32'(sync_frame_r);
      default:           rd_mux = '0;
    endcase
  end

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_forward;
    setup_valid && rq.forward |=> ct_r == CT_CPU && irq_stat[`USR_IRQ_SET];
  endproperty
  a_forward: assert property (p_forward)
    else $error("forwarded setup not raised to cpu");

  property p_set_cfg;
    req_set_cfg |=> cfg_r == $past(rq.wvalue[3:0]) && active_r[3:0] == 4'h0;
  endproperty
  a_set_cfg: assert property (p_set_cfg)
    else $error("configuration select not applied");

  property p_active_cause;
    $changed(active_r) |-> $past(req_set_cfg) || $past(req_set_if);
  endproperty
  a_active_cause: assert property (p_active_cause)
    else $error("active report changed without a select");

  property p_halt;
    (req_set_feat || req_clr_feat) && ep_ok && rq.wvalue == `USR_FEAT_HALT
      |=> halt_r[$past(ep_n)] == $past(req_set_feat);
  endproperty
  a_halt: assert property (p_halt)
    else $error("endpoint halt feature not updated");

  property p_wake;
    req_set_feat && rq.recip == `USR_RCP_DEV && rq.wvalue == `USR_FEAT_WAKE
      |=> remote_wake_en;
  endproperty
  a_wake: assert property (p_wake)
    else $error("remote wakeup not enabled");

  property p_addr;
    $changed(dev_addr_r) |-> $past(status_done) && $past(addr_pend_r);
  endproperty
  a_addr: assert property (p_addr)
    else $error("address moved before status completion");

  property p_ack_after_op;
    setup_valid && !rq.forward |-> !status_ack_en ##1 status_ack_en;
  endproperty
  a_ack_after_op: assert property (p_ack_after_op)
    else $error("status ack not sequenced after the operation");

  property p_get_cfg;
    req_get_cfg |=> resp_valid && resp_data == {12'h000, cfg_r};
  endproperty
  a_get_cfg: assert property (p_get_cfg)
    else $error("wrong configuration answer");

  property p_get_if;
    req_get_if && !configured |=> resp_stall && !resp_valid ##1 irq_stat[`USR_IRQ_GIF];
  endproperty
  a_get_if: assert property (p_get_if)
    else $error("get interface answered while unconfigured");

  property p_sts_irq;
    status_req && !status_ack_en |=> irq_stat[`USR_IRQ_STS];
  endproperty
  a_sts_irq: assert property (p_sts_irq)
    else $error("status stage interrupt missing");

endmodule // usr_std_req

// file: dv/usr_host_model.sv
// usr_host_model: host side of the endpoint-0 link strobes
// assumes one clk shared with the handler; the bench calls the tasks
`timescale 1ns/1ps
module usr_host_model (
  input  wire logic        clk,
  output logic             setup_valid,
  output logic [63:0]      setup_pkt,
  output logic             status_req,
  output logic             status_done,
  output logic             sof_valid,
  output logic [10:0]      sof_frame,
  output logic             pattern_start
);
  initial begin
    setup_valid = 1'b0;
    setup_pkt = 64'h0;
    status_req = 1'b0;
    status_done = 1'b0;
    sof_valid = 1'b0;
    sof_frame = 11'h0;
    pattern_start = 1'b0;
  end

  // packet bus is not held after the strobe, so show the inverse
  task automatic setup(input logic [63:0] p);
    @(posedge clk);
    setup_valid <= 1'b1;
    setup_pkt <= p;
    @(posedge clk);
    setup_valid <= 1'b0;
    setup_pkt <= ~p;
  endtask

  // status token only after the setup edge has been taken
  task automatic stage(input logic fin);
    @(posedge clk);
    status_req <= 1'b1;
    @(posedge clk);
    status_req <= 1'b0;
    status_done <= fin;
    @(posedge clk);
    status_done <= 1'b0;
  endtask

  // pattern marked in the frame after its sof
  task automatic frame(input logic [10:0] f, input logic pat);
    @(posedge clk);
    sof_valid <= 1'b1;
    sof_frame <= f;
    @(posedge clk);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
    pattern_start <= pat;
    @(posedge clk);
    pattern_start <= 1'b0;
  endtask
endmodule // usr_host_model

// file: dv/usr_std_req_bench.sv
// usr_std_req_bench: directed tests of the endpoint-0 request handler
// assumes usr_host_model drives the link; the bench acts as cpu on avalon
`timescale 1ns/1ps
`include "usr_defines.svh"
module usr_std_req_bench
  import usr_pkg::*;
;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        setup_valid, status_req, status_done, sof_valid, pattern_start;
  logic [63:0] setup_pkt;
  logic [10:0] sof_frame;
  logic [6:0]  dev_addr;
  logic        status_ack_en, resp_valid, resp_stall, remote_wake_en;
  logic [15:0] resp_data, ep_halt;
  logic [1:0]  resp_len;
  int          err_total, checks;

  usr_std_req dut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .setup_valid(setup_valid), .setup_pkt(setup_pkt), .status_req(status_req),
    .status_done(status_done), .sof_valid(sof_valid), .sof_frame(sof_frame),
    .pattern_start(pattern_start), .dev_addr(dev_addr), .status_ack_en(status_ack_en),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_len(resp_len),
    .resp_stall(resp_stall), .ep_halt(ep_halt), .remote_wake_en(remote_wake_en),
    .irq(irq));

  usr_host_model hm (.clk(clk), .setup_valid(setup_valid), .setup_pkt(setup_pkt),
    .status_req(status_req), .status_done(status_done), .sof_valid(sof_valid),
    .sof_frame(sof_frame), .pattern_start(pattern_start));

  always #2.5 clk = ~clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon access; the request is held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  function automatic logic [63:0] sp(input logic [7:0] rt, input logic [7:0] rq,
                                     input logic [15:0] v, input logic [15:0] i);
    return {16'h0002, i, v, rq, rt};
  endfunction

  // au: whether the handler may acknowledge the status stage by itself
  task automatic req(input logic [63:0] p, input logic au);
    hm.setup(p);
    @(negedge clk);
    chk("status_ack_en", 32'(au), 32'(status_ack_en));
  endtask

  task automatic fin();
    hm.stage(1'b1);
    @(negedge clk);
  endtask

  task automatic t_reset();
    rdc("ctrl", `USR_REG_CTRL, 32'h0);
    rdc("active", `USR_REG_ACTIVE, {20'h0, `USR_ACTIVE_RST});
    rdc("addr", `USR_REG_ADDR, {25'h0, `USR_ADDR_RST});
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    rdc("unmapped", 4'hF, 32'h0);
    bus(1'b1, `USR_REG_ACTIVE, 32'h0000_0FFF);
    rdc("active read only", `USR_REG_ACTIVE, 32'h0);
    bus(1'b1, `USR_REG_CTRL, 32'h2);
    rdc("ctrl self powered", `USR_REG_CTRL, 32'h2);
    $display("test reset done");
  endtask

  task automatic t_unconf();
    req(sp(8'h81, 8'h0A, 16'h0, 16'h0), 1'b1);
    chk("stall", 32'h1, 32'(resp_stall));
    fin();
    req(sp(8'h01, 8'h0B, 16'h0001, 16'h0001), 1'b1);
    chk("set if stall", 32'h1, 32'(resp_stall));
    fin();
    req(sp(8'h80, 8'h08, 16'h0, 16'h0), 1'b1);
    chk("config value", 32'h0, 32'(resp_data));
    chk("config len", 32'(`USR_LEN_BYTE), 32'(resp_len));
    fin();
    $display("test unconfigured done");
  endtask

  task automatic t_address();
    req(sp(8'h00, 8'h05, 16'h0005, 16'h0), 1'b1);
    chk("addr after setup", 32'h0, 32'(dev_addr));
    hm.stage(1'b0);
    @(negedge clk);
    chk("addr after token", 32'h0, 32'(dev_addr));
    fin();
    chk("addr after status", 32'h5, 32'(dev_addr));
    req(sp(8'h00, 8'h05, 16'h0009, 16'h0), 1'b1);
    req(sp(8'h80, 8'h08, 16'h0, 16'h0), 1'b1);
    fin();
    chk("aborted address", 32'h5, 32'(dev_addr));
    rdc("addr reg", `USR_REG_ADDR, 32'h5);
    $display("test address done");
  endtask

  task automatic t_config();
    bus(1'b1, `USR_REG_IRQ_MASK, 32'hF);
    bus(1'b1, `USR_REG_IRQ_STAT, 32'hF);
    req(sp(8'h00, 8'h09, 16'h0002, 16'h0), 1'b1);
    fin();
    chk("irq on change", 32'h1, 32'(irq));
    rdc("active cfg", `USR_REG_ACTIVE, 32'h200);
    rdc("stat change", `USR_REG_IRQ_STAT, 32'h1);
    bus(1'b1, `USR_REG_IRQ_STAT, 32'h1);
    @(negedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    req(sp(8'h01, 8'h0B, 16'h0003, 16'h0001), 1'b1);
    fin();
    rdc("active alt", `USR_REG_ACTIVE, 32'h213);
    req(sp(8'h81, 8'h0A, 16'h0, 16'h0001), 1'b1);
    chk("alt value", 32'h3, 32'(resp_data));
    chk("alt len", 32'(`USR_LEN_BYTE), 32'(resp_len));
    chk("alt stall", 32'h0, 32'(resp_stall));
    chk("alt valid", 32'h1, 32'(resp_valid));
    fin();
    rdc("stat notify", `USR_REG_IRQ_STAT, 32'h9);
    bus(1'b1, `USR_REG_IRQ_STAT, 32'hF);
    req(sp(8'h81, 8'h0A, 16'h0, 16'h0011), 1'b1);
    chk("missing if stall", 32'h0, 32'(resp_stall));
    chk("missing if value", 32'h0, 32'(resp_data));
    fin();
    req(sp(8'h80, 8'h08, 16'h0, 16'h0), 1'b1);
    chk("config value", 32'h2, 32'(resp_data));
    fin();
    bus(1'b1, `USR_REG_IRQ_STAT, 32'hF);
    bus(1'b1, `USR_REG_IRQ_MASK, 32'hE);
    req(sp(8'h00, 8'h09, 16'h0001, 16'h0), 1'b1);
    fin();
    chk("masked irq", 32'h0, 32'(irq));
    rdc("active reset alt", `USR_REG_ACTIVE, 32'h100);
    bus(1'b1, `USR_REG_IRQ_MASK, 32'hF);
    @(negedge clk);
    chk("unmasked irq", 32'h1, 32'(irq));
    bus(1'b1, `USR_REG_IRQ_STAT, 32'hF);
    $display("test config done");
  endtask

  task automatic t_feature();
    req(sp(8'h02, 8'h03, `USR_FEAT_HALT, 16'h0003), 1'b1);
    chk("halt set", 32'h8, 32'(ep_halt));
    fin();
    req(sp(8'h82, 8'h00, 16'h0, 16'h0003), 1'b1);
    chk("ep status", 32'h1, 32'(resp_data));
    chk("ep status len", 32'(`USR_LEN_WORD), 32'(resp_len));
    fin();
    req(sp(8'h02, 8'h01, `USR_FEAT_HALT, 16'h0003), 1'b1);
    chk("halt clear", 32'h0, 32'(ep_halt));
    fin();
    req(sp(8'h00, 8'h03, `USR_FEAT_WAKE, 16'h0), 1'b1);
    chk("wake set", 32'h1, 32'(remote_wake_en));
    fin();
    req(sp(8'h80, 8'h00, 16'h0, 16'h0), 1'b1);
    chk("dev status", 32'h3, 32'(resp_data));
    fin();
    req(sp(8'h00, 8'h01, `USR_FEAT_WAKE, 16'h0), 1'b1);
    chk("wake clear", 32'h0, 32'(remote_wake_en));
    fin();
    $display("test feature done");
  endtask

  task automatic t_forward();
    logic [7:0] rt[3] = '{8'h80, 8'h00, 8'h82};
    logic [7:0] rq[3] = '{8'h06, 8'h07, 8'h0C};
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `USR_REG_IRQ_STAT, 32'hF);
      req(sp(rt[k], rq[k], 16'h0100, 16'h0), 1'b0);
      rdc("stat setup", `USR_REG_IRQ_STAT, 32'h2);
      rdc("setup lo", `USR_REG_SETUP_LO, {16'h0100, rq[k], rt[k]});
      rdc("ctrl cpu state", `USR_REG_CTRL, 32'hA);
      hm.stage(1'b0);
      rdc("stat status", `USR_REG_IRQ_STAT, 32'h6);
      bus(1'b1, `USR_REG_CTRL, 32'h3);
      @(negedge clk);
      chk("cpu ack enable", 32'h1, 32'(status_ack_en));
      fin();
    end
    $display("test forward done");
  endtask

  task automatic t_sync();
    hm.frame(11'h122, 1'b0);
    hm.frame(11'h123, 1'b1);
    hm.frame(11'h124, 1'b0);
    rdc("sync frame", `USR_REG_SYNC, 32'h123);
    $display("test sync done");
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_unconf();
    t_address();
    t_config();
    t_feature();
    t_forward();
    t_sync();
    complete_run();
  end

  // the tests take a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule // usr_std_req_bench
